// ---- hw/pin_select_pkg.sv ----
// Purpose: Shared constants for the remappable input selector
// Assumes: 16-bit register port, 10 MHz system clock
// Notes: Register offsets are word indices on the plain register port
package pin_select_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CODE_W = 8;
  localparam int PIN_COUNT = 182;
  localparam logic [CODE_W-1:0] MAX_PIN_CODE = 8'hB5;
  localparam logic [ADDR_W-1:0] CAPTURE_SEL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] COMPARE_FAULT_SEL_OFFSET = 4'h1;
  localparam logic [ADDR_W-1:0] PWM_FAULT_SEL_OFFSET = 4'h2;
  localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
  localparam logic [CODE_W-1:0] CODE_TIED_LOW = 8'h00;
  localparam int LOW_CODE_LSB = 0;
  localparam int HIGH_CODE_LSB = 8;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;
endpackage

// ---- hw/pin_code_reg.sv ----
// Purpose: One 8-bit pin selection code held in flip-flops
// Assumes: Synchronous active-high reset
// Notes: Written as a whole byte
`timescale 1ns/1ps
module pin_code_reg
  import pin_select_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Write side
  input wire logic wr_en_i,
  input wire logic [CODE_W-1:0] wr_code_i,
  // Stored code
  output logic [CODE_W-1:0] code_o
);
  logic [CODE_W-1:0] code_reg;
  logic [CODE_W-1:0] code_next;

  always_comb begin
    code_next = code_reg;
    if (wr_en_i) begin
      code_next = wr_code_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      code_reg <= CODE_RESET;
    end else begin
      code_reg <= code_next;
    end
  end

  assign code_o = code_reg;
endmodule // pin_code_reg

// ---- hw/pin_route.sv ----
// Purpose: Routes one remappable pin to a peripheral input by code
// Assumes: Pins are synchronous to the system clock
// Notes: Output is registered, one cycle behind the pin
`timescale 1ns/1ps
module pin_route
  import pin_select_pkg::*;
#(
  parameter int PINS = PIN_COUNT
)(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Selection
  input wire logic [CODE_W-1:0] code_i,
  input wire logic [PINS-1:0] pins_i,
  // Routed input
  output logic routed_o
);
  logic routed_reg;
  logic routed_next;

  always_comb begin
    routed_next = 1'b0;
    if (code_i != CODE_TIED_LOW && 32'(code_i) < PINS) begin
      routed_next = pins_i[code_i];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      routed_reg <= 1'b0;
    end else begin
      routed_reg <= routed_next;
    end
  end

  assign routed_o = routed_reg;
endmodule // pin_route

// ---- hw/remappable_input_selector.sv ----
// Purpose: Connects peripheral inputs to remappable pins chosen by software
// Assumes: Pins synchronous to mclk_i; register port never waits
// Notes: Routed inputs lag their pin by one clock
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Capture input follows pin numbered by code
// - Compare fault input follows its coded pin
// - Code zero ties the input low
// - Upper byte of single selectors reads zero
// - Pair register: fault one low, two high
// - All codes read/write, reset to zero
module remappable_input_selector
  import pin_select_pkg::*;
#(
  parameter int PINS = PIN_COUNT
)(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // Pins
  input wire logic [PINS-1:0] remappable_pin_i,
  // Peripheral inputs
  output logic input_capture_one_o,
  output logic compare_fault_a_input_o,
  output logic pwm_fault_one_input_o,
  output logic pwm_fault_two_input_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Selector decode
  localparam int NSEL = 4;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic [CODE_W-1:0] code [NSEL];
  logic [NSEL-1:0] code_wr;
  logic [CODE_W-1:0] code_wdata [NSEL];
  logic [NSEL-1:0] routed;

  logic [CODE_W-1:0] capture_source_code;
  logic [CODE_W-1:0] compare_fault_source_code;
  logic [CODE_W-1:0] pwm_fault_one_source_code;
  logic [CODE_W-1:0] pwm_fault_two_source_code;

  always_comb begin
    code_wr[0] = reg_wr_i && hit(reg_addr_i, CAPTURE_SEL_OFFSET);
    code_wr[1] = reg_wr_i && hit(reg_addr_i, COMPARE_FAULT_SEL_OFFSET);
    code_wr[2] = reg_wr_i && hit(reg_addr_i, PWM_FAULT_SEL_OFFSET);
    code_wr[3] = code_wr[2];
    code_wdata[0] = reg_wdata_i[LOW_CODE_LSB +: CODE_W];
    code_wdata[1] = reg_wdata_i[LOW_CODE_LSB +: CODE_W];
    code_wdata[2] = reg_wdata_i[LOW_CODE_LSB +: CODE_W];
    code_wdata[3] = reg_wdata_i[HIGH_CODE_LSB +: CODE_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code storage and routing, one slice per peripheral input
  genvar g;
  generate
    for (g = 0; g < NSEL; g++) begin : g_sel
      pin_code_reg u_code (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(code_wr[g]),
        .wr_code_i(code_wdata[g]),
        .code_o(code[g])
      );
      pin_route #(.PINS(PINS)) u_route (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .code_i(code[g]),
        .pins_i(remappable_pin_i),
        .routed_o(routed[g])
      );
    end
  endgenerate

  assign capture_source_code = code[0];
  assign compare_fault_source_code = code[1];
  assign pwm_fault_one_source_code = code[2];
  assign pwm_fault_two_source_code = code[3];

  assign input_capture_one_o = routed[0];
  assign compare_fault_a_input_o = routed[1];
  assign pwm_fault_one_input_o = routed[2];
  assign pwm_fault_two_input_o = routed[3];

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data appears the cycle after the strobe, zero otherwise
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  always_comb begin
    rdata_next = UNMAPPED_READ;
    if (reg_rd_i) begin
      case (reg_addr_i)
        CAPTURE_SEL_OFFSET: begin
          rdata_next = {8'h00, capture_source_code};
        end
        COMPARE_FAULT_SEL_OFFSET: begin
          rdata_next = {8'h00, compare_fault_source_code};
        end
        PWM_FAULT_SEL_OFFSET: begin
          rdata_next = {pwm_fault_two_source_code, pwm_fault_one_source_code};
        end
        default: begin
          rdata_next = UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= UNMAPPED_READ;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence cap_write_s;
    reg_wr_i && reg_addr_i == CAPTURE_SEL_OFFSET;
  endsequence

  sequence cap_read_s;
    reg_rd_i && reg_addr_i == CAPTURE_SEL_OFFSET;
  endsequence

  capture_route_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (capture_source_code != 8'h00 && 32'(capture_source_code) < PINS)
      |=> input_capture_one_o == $past(remappable_pin_i[capture_source_code]))
    else $error("capture input not following selected pin");

  fault_route_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (compare_fault_source_code != 8'h00 && 32'(compare_fault_source_code) < PINS)
      |=> compare_fault_a_input_o == $past(remappable_pin_i[compare_fault_source_code]))
    else $error("compare fault input not following selected pin");

  zero_tie_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (pwm_fault_one_source_code == 8'h00) ##1 (pwm_fault_one_source_code == 8'h00)
      |-> !pwm_fault_one_input_o)
    else $error("zero code did not tie input low");

  upper_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cap_read_s |=> reg_rdata_o[15:8] == 8'h00)
    else $error("unimplemented upper byte read nonzero");

  pair_read_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == PWM_FAULT_SEL_OFFSET
      |=> reg_rdata_o == {$past(pwm_fault_two_source_code), $past(pwm_fault_one_source_code)})
    else $error("pwm fault pair read mismatch");

  write_read_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cap_write_s ##1 cap_read_s |=> reg_rdata_o == {8'h00, $past(reg_wdata_i[7:0], 2)})
    else $error("capture code write not read back");

  reset_clear_a: assert property (@(posedge mclk_i)
    sys_rst_i |=> capture_source_code == 8'h00 && pwm_fault_two_source_code == 8'h00)
    else $error("codes not cleared by reset");

  high_code_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (32'(pwm_fault_two_source_code) >= PINS) |=> !pwm_fault_two_input_o)
    else $error("out of range code did not tie input low");

  sequence cmp_write_s;
    reg_wr_i && reg_addr_i == COMPARE_FAULT_SEL_OFFSET;
  endsequence

  sequence cmp_read_s;
    reg_rd_i && reg_addr_i == COMPARE_FAULT_SEL_OFFSET;
  endsequence

  sequence pair_write_s;
    reg_wr_i && reg_addr_i == PWM_FAULT_SEL_OFFSET;
  endsequence

  sequence pair_read_s;
    reg_rd_i && reg_addr_i == PWM_FAULT_SEL_OFFSET;
  endsequence

  fault_one_route_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (pwm_fault_one_source_code != 8'h00 && 32'(pwm_fault_one_source_code) < PINS)
      |=> pwm_fault_one_input_o == $past(remappable_pin_i[pwm_fault_one_source_code]))
    else $error("pwm fault one input not following selected pin");

  fault_two_route_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (pwm_fault_two_source_code != 8'h00 && 32'(pwm_fault_two_source_code) < PINS)
      |=> pwm_fault_two_input_o == $past(remappable_pin_i[pwm_fault_two_source_code]))
    else $error("pwm fault two input not following selected pin");

  capture_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (capture_source_code == 8'h00) ##1 (capture_source_code == 8'h00)
      |-> !input_capture_one_o)
    else $error("zero code did not tie capture input low");

  compare_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (compare_fault_source_code == 8'h00) ##1 (compare_fault_source_code == 8'h00)
      |-> !compare_fault_a_input_o)
    else $error("zero code did not tie compare fault input low");

  two_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (pwm_fault_two_source_code == 8'h00) ##1 (pwm_fault_two_source_code == 8'h00)
      |-> !pwm_fault_two_input_o)
    else $error("zero code did not tie pwm fault two input low");

  capture_high_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (32'(capture_source_code) >= PINS) |=> !input_capture_one_o)
    else $error("out of range code did not tie capture input low");

  compare_high_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (32'(compare_fault_source_code) >= PINS) |=> !compare_fault_a_input_o)
    else $error("out of range code did not tie compare fault input low");

  one_high_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (32'(pwm_fault_one_source_code) >= PINS) |=> !pwm_fault_one_input_o)
    else $error("out of range code did not tie pwm fault one input low");

  compare_upper_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cmp_read_s |=> reg_rdata_o[15:8] == 8'h00)
    else $error("compare fault upper byte read nonzero");

  idle_read_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside a read");

  capture_take_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cap_write_s |=> capture_source_code == $past(reg_wdata_i[7:0]))
    else $error("capture code not taken from write");

  compare_take_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cmp_write_s |=> compare_fault_source_code == $past(reg_wdata_i[7:0]))
    else $error("compare fault code not taken from write");

  pair_take_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    pair_write_s |=> {pwm_fault_two_source_code, pwm_fault_one_source_code}
      == $past(reg_wdata_i))
    else $error("pwm fault pair codes not taken from write");

  capture_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !reg_wr_i |=> $stable(capture_source_code))
    else $error("capture code changed without a write");

  compare_readback_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cmp_write_s ##1 cmp_read_s |=> reg_rdata_o == {8'h00, $past(reg_wdata_i[7:0], 2)})
    else $error("compare fault code write not read back");

  pair_readback_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    pair_write_s ##1 pair_read_s |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("pwm fault pair write not read back");

  reset_codes_a: assert property (@(posedge mclk_i)
    sys_rst_i |=> compare_fault_source_code == 8'h00 && pwm_fault_one_source_code == 8'h00)
    else $error("remaining codes not cleared by reset");

  reset_outputs_a: assert property (@(posedge mclk_i)
    sys_rst_i |=> !input_capture_one_o && !compare_fault_a_input_o
      && !pwm_fault_one_input_o && !pwm_fault_two_input_o && reg_rdata_o == 16'h0000)
    else $error("outputs not cleared by reset");

endmodule // remappable_input_selector

// ---- bench/pin_bank_model.sv ----
// Purpose: Stands in for the external remappable pins
// Assumes: Pins change just after the rising edge of mclk_i
// Notes: Fresh random word every cycle, spread over all pins
`timescale 1ns/1ps
module pin_bank_model
  import pin_select_pkg::*;
#(
  parameter int PINS = PIN_COUNT
)(
  // Clock
  input wire logic mclk_i,
  // Random source
  input wire logic [31:0] noise_i,
  // Pin levels
  output logic [PINS-1:0] pins_o
);
  // Levels change every cycle so a stale routing path cannot match by luck
  always_ff @(posedge mclk_i) begin
    pins_o <= PINS'({6{noise_i}});
  end
endmodule // pin_bank_model

// ---- bench/test_remappable_input_selector.sv ----
// Purpose: Self-checking bench for the remappable input selector
// Assumes: Codes take effect one edge after the write, outputs lag pins by one
// Notes: Routing notes are queued at the falling edge, read notes at the rising edge; all are checked at the rising edge
`timescale 1ns/1ps
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module test_remappable_input_selector
  import pin_select_pkg::*;
;
  logic mclk_i, sys_rst_i, reg_wr_i, reg_rd_i, rd_seen;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
  logic [PIN_COUNT-1:0] pins;
  logic ic_o, cf_o, f1_o, f2_o;
  logic [31:0] noise, rng;
  logic [CODE_W-1:0] sh [4];
  logic [CODE_W-1:0] codes [6] = '{8'hB5, 8'hB4, 8'h01, 8'h00, 8'hB6, 8'hFF};
  logic [3:0] route_q [$];
  logic [3:0] route_exp;
  logic [DATA_W-1:0] rd_exp;
  logic [DATA_W-1:0] rd_q [$];
  int checked = 0;
  int miscompares = 0;
  ////////////////////////////////////////////////////////////////////////////
  remappable_input_selector #(.PINS(PIN_COUNT)) remappable_input_selector_i (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .remappable_pin_i(pins), .input_capture_one_o(ic_o),
    .compare_fault_a_input_o(cf_o), .pwm_fault_one_input_o(f1_o),
    .pwm_fault_two_input_o(f2_o));
  pin_bank_model #(.PINS(PIN_COUNT)) pin_bank_model_i (
    .mclk_i(mclk_i), .noise_i(noise), .pins_o(pins));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic rt(input logic [CODE_W-1:0] c, input logic [PIN_COUNT-1:0] p);
    return (c == CODE_TIED_LOW || c > MAX_PIN_CODE) ? 1'b0 : p[c];
  endfunction
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    rd_q.push_back(e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    rng = xorshift(rng);
    noise <= rng;
    // Shadow codes follow the writes the design takes at this edge
    if (sys_rst_i) sh <= '{default: CODE_RESET};
    else if (reg_wr_i && reg_addr_i == CAPTURE_SEL_OFFSET) sh[0] <= reg_wdata_i[7:0];
    else if (reg_wr_i && reg_addr_i == COMPARE_FAULT_SEL_OFFSET) sh[1] <= reg_wdata_i[7:0];
    else if (reg_wr_i && reg_addr_i == PWM_FAULT_SEL_OFFSET) begin
      sh[2] <= reg_wdata_i[7:0];
      sh[3] <= reg_wdata_i[15:8];
    end
  end
  always @(negedge mclk_i) begin
    if (sys_rst_i) route_q.delete();
    else route_q.push_back({rt(sh[0], pins), rt(sh[1], pins), rt(sh[2], pins), rt(sh[3], pins)});
  end
  // Watcher: one routing note per cycle, one read note per read strobe
  always @(posedge mclk_i) begin
    rd_seen <= reg_rd_i && !sys_rst_i;
    // Pop once so a mismatch report shows the same note that was compared
    if (route_q.size() == 2) begin
      route_exp = route_q.pop_front();
      `CHECK({ic_o, cf_o, f1_o, f2_o}, route_exp)
    end
    if (rd_seen) begin
      rd_exp = rd_q.pop_front();
      `CHECK(reg_rdata_o, rd_exp)
    end
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    miscompares++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    sys_rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    rd_seen = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    rng = 32'h9;
    noise = 32'h9;
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int a = 0; a < 3; a++) reg_read(ADDR_W'(a), 16'h0000);
    reg_write(4'hF, 16'hFFFF);
    reg_read(4'hF, UNMAPPED_READ);
    foreach (codes[i]) begin
      reg_write(CAPTURE_SEL_OFFSET, {8'hFF, codes[i]});
      reg_write(COMPARE_FAULT_SEL_OFFSET, {8'hA5, codes[i]});
      reg_write(PWM_FAULT_SEL_OFFSET, {codes[i], ~codes[i]});
      reg_read(CAPTURE_SEL_OFFSET, {8'h00, codes[i]});
      reg_read(COMPARE_FAULT_SEL_OFFSET, {8'h00, codes[i]});
      reg_read(PWM_FAULT_SEL_OFFSET, {codes[i], ~codes[i]});
      repeat (8) @(posedge mclk_i);
    end
    // Random codes, index 3 among them is unmapped and must change nothing
    repeat (40) begin
      reg_write({2'b00, noise[9:8]}, noise[31:16]);
      repeat (6) @(posedge mclk_i);
    end
    results();
  end
endmodule // test_remappable_input_selector
